// File: scr_edge_sync.sv
// synchroniser with rising and falling edge detection
`timescale 1ns/1ps
module scr_edge_sync import scr_pkg::*; #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // asynchronous level in, edge pulses out
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] rise,
    output logic [WIDTH-1:0] fall
);
    logic [WIDTH-1:0] stage1, stage2, stage3;
    logic [WIDTH-1:0] next_stage1, next_stage2, next_stage3;

    // stage1 feeds only stage2
    always_comb begin
        next_stage1 = pinIn;
        next_stage2 = stage1;
        next_stage3 = stage2;
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end else begin
            stage1 <= next_stage1;
            stage2 <= next_stage2;
            stage3 <= next_stage3;
        end
    end

    // edge pulses from the settled stages
    assign level = stage2;
    assign rise = stage2 & ~stage3;
    assign fall = ~stage2 & stage3;
endmodule

// File: scr_pkg.sv
// package: register map, field layout, reset values and timing constants
package scr_pkg;
    // register byte addresses on the wishbone bus
    localparam logic [7:0] ADDR_CTRL_ZERO = 8'h00;
    localparam logic [7:0] ADDR_CTRL_ONE = 8'h04;
    localparam logic [7:0] ADDR_WAKE_SEL = 8'h08;
    localparam logic [7:0] ADDR_PULL_A = 8'h0C;
    localparam logic [7:0] ADDR_PULL_B = 8'h10;
    localparam logic [7:0] ADDR_LCD_COM = 8'h14;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h18;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h1C;
    localparam logic [7:0] ADDR_SYS_STAT = 8'h20;
    // field positions of system_control_one
    localparam int EDGE_POS = 6;
    localparam int TB_POS = 4;
    localparam int WDOG_POS = 0;
    // reset values
    localparam logic [7:0] CTRL_ONE_RST = 8'h8A;
    localparam logic [7:0] CTRL_ZERO_RST = 8'h00;
    localparam logic [3:0] WDOG_OFF_CODE = 4'hA;
    localparam logic [3:0] WDOG_ON_CODE = 4'h5;
    // edge select codes
    localparam logic [1:0] EDGE_NONE = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    // interrupt status bit positions
    localparam int IRQ_EXT = 0;
    localparam int IRQ_TB = 1;
    localparam int IRQ_WAKE = 2;
    // time base exponent for code 00
    localparam int TB_EXP_BASE = 10;
    // clock and mux handover: two mclk cycles of settle per switch
    localparam int CLK_PERIOD_NS = 5;
    localparam int SWITCH_SETTLE_NS = 10;
    localparam int SWITCH_CYCLES = (SWITCH_SETTLE_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    // oscillator configuration option codes
    typedef enum logic [2:0] {
        SCR_OSC_FAST_XTAL = 3'h0,
        SCR_OSC_EXT_RC = 3'h1,
        SCR_OSC_FAST_RC = 3'h2,
        SCR_OSC_RC_SLOW_XTAL = 3'h3
    } scr_osc_cfg_t;
    // clock switch states, gray along fast->gating->slow
    typedef enum logic [1:0] {
        SCR_CK_FAST = 2'b00,
        SCR_CK_GATE = 2'b01,
        SCR_CK_SLOW = 2'b11,
        SCR_CK_BACK = 2'b10
    } scr_ck_state_t;
    // time base terminal count, one less than the period in source clocks, for a select code
    function automatic logic [13:0] scr_tb_limit(input logic [1:0] sel);
        scr_tb_limit = 14'(14'h0001 << (TB_EXP_BASE + int'(sel))) - 14'h0001;
    endfunction
endpackage

// File: scr_regs.sv
// system control register bank with wishbone slave and clock mode control
`timescale 1ns/1ps
module scr_regs import scr_pkg::*; #(
    parameter int PA_WIDTH = 8,
    parameter int PB_WIDTH = 8
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // configuration options
    input wire logic [2:0] oscConfig,
    input wire logic wdogOption,
    // oscillator ticks, synchronous to mclk
    input wire logic fastRcTick,
    input wire logic slowXtalTick,
    input wire logic slowRcTick,
    // core status
    input wire logic haltExec,
    input wire logic [PA_WIDTH-1:0] portAIn,
    input wire logic [PA_WIDTH-1:0] portADirIn,
    input wire logic [PB_WIDTH-1:0] portBDirIn,
    input wire logic extIrqPin,
    // controls out
    output logic fastRcEnable,
    output logic sysClkSlow,
    output logic sysClkGate,
    output logic watchdogEnable,
    output logic watchdogTick,
    output logic timebaseTick,
    output logic lowPower,
    output logic wakeUp,
    output logic [PA_WIDTH-1:0] portAPullEn,
    output logic [PB_WIDTH-1:0] portBPullEn,
    output logic [3:0] lcdComDrive,
    output logic [3:0] lcdComEnable,
    output logic extRcPinSel,
    output logic irq
);
    logic [7:0] ctrlZero, ctrlOne, lcdCom;
    logic [PA_WIDTH-1:0] wakeSel, pullA;
    logic [PB_WIDTH-1:0] pullB;
    logic [2:0] irqStat, irqMask;
    logic [7:0] next_ctrlZero, next_ctrlOne, next_lcdCom;
    logic [PA_WIDTH-1:0] next_wakeSel, next_pullA;
    logic [PB_WIDTH-1:0] next_pullB;
    logic [2:0] next_irqStat, next_irqMask;
    logic next_ack, next_lowPower;
    logic [31:0] next_dat;
    logic wrStrobe, extRise, extFall, extHit, tbPulse, modeValid;
    logic [PA_WIDTH-1:0] paFall;
    scr_ck_state_t ckState, next_ckState;
    logic [1:0] settle, next_settle;

    // ************************************************
    // edge detection and time base
    // ************************************************

    // synchronise the external interrupt pin and port a
    scr_edge_sync #(.WIDTH(1)) uExtSync (
        .mclk(mclk),
        .rst_b(rst_b),
        .pinIn(extIrqPin),
        .level(),
        .rise(extRise),
        .fall(extFall)
    );

    scr_edge_sync #(.WIDTH(PA_WIDTH)) uWakeSync (
        .mclk(mclk),
        .rst_b(rst_b),
        .pinIn(portAIn),
        .level(),
        .rise(),
        .fall(paFall)
    );

    // slow crystal feeds the time base when present, else the slow rc
    assign modeValid = (oscConfig == SCR_OSC_RC_SLOW_XTAL);
    assign timebaseTick = modeValid ? slowXtalTick : slowRcTick;
    assign watchdogTick = slowRcTick;

    scr_timebase uTimebase (
        .mclk(mclk),
        .rst_b(rst_b),
        .srcTick(timebaseTick),
        .periodSel(ctrlOne[TB_POS +: 2]),
        .tbPulse(tbPulse)
    );

    // edge select decode
    always_comb begin
        unique case (ctrlOne[EDGE_POS +: 2])
            EDGE_NONE: extHit = 1'b0;
            EDGE_RISE: extHit = extRise;
            EDGE_FALL: extHit = extFall;
            EDGE_BOTH: extHit = extRise | extFall;
        endcase
    end

    // ************************************************
    // wishbone register access
    // ************************************************

    // a write lands on the edge at which the master sees ack high
    assign wrStrobe = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0]
        && wb_ack_o;

    // register next values; hardware set wins over write-one clear
    always_comb begin
        next_ctrlZero = ctrlZero;
        next_ctrlOne = ctrlOne;
        next_lcdCom = lcdCom;
        next_wakeSel = wakeSel;
        next_pullA = pullA;
        next_pullB = pullB;
        next_irqMask = irqMask;
        next_irqStat = irqStat;
        next_lowPower = lowPower;
        if (wrStrobe) begin
            unique case (wb_adr_i)
                ADDR_CTRL_ZERO: next_ctrlZero = {4'h0, wb_dat_i[3:0]};
                ADDR_CTRL_ONE: next_ctrlOne = wb_dat_i[7:0];
                ADDR_WAKE_SEL: next_wakeSel = wb_dat_i[PA_WIDTH-1:0];
                ADDR_PULL_A: next_pullA = wb_dat_i[PA_WIDTH-1:0];
                ADDR_PULL_B: next_pullB = wb_dat_i[PB_WIDTH-1:0];
                ADDR_LCD_COM: next_lcdCom = wb_dat_i[7:0];
                ADDR_IRQ_STAT: next_irqStat = irqStat & ~wb_dat_i[2:0];
                ADDR_IRQ_MASK: next_irqMask = wb_dat_i[2:0];
                default: ;
            endcase
        end
        if (extHit) next_irqStat[IRQ_EXT] = 1'b1;
        if (tbPulse) next_irqStat[IRQ_TB] = 1'b1;
        // halt enters low power whatever the mode bit holds
        if (haltExec) next_lowPower = 1'b1;
        if (lowPower && |(paFall & wakeSel)) begin
            next_lowPower = 1'b0;
            next_irqStat[IRQ_WAKE] = 1'b1;
        end
    end

    // read mux and single-cycle ack
    always_comb begin
        next_ack = wb_cyc_i && wb_stb_i && !wb_ack_o;
        next_dat = '0;
        unique case (wb_adr_i)
            ADDR_CTRL_ZERO: next_dat[7:0] = ctrlZero;
            ADDR_CTRL_ONE: next_dat[7:0] = ctrlOne;
            ADDR_WAKE_SEL: next_dat[PA_WIDTH-1:0] = wakeSel;
            ADDR_PULL_A: next_dat[PA_WIDTH-1:0] = pullA;
            ADDR_PULL_B: next_dat[PB_WIDTH-1:0] = pullB;
            ADDR_LCD_COM: next_dat[7:0] = lcdCom;
            ADDR_IRQ_STAT: next_dat[2:0] = irqStat;
            ADDR_IRQ_MASK: next_dat[2:0] = irqMask;
            ADDR_SYS_STAT: next_dat[3:0] = {lowPower, watchdogEnable,
                ckState};
            default: ;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            ctrlZero <= CTRL_ZERO_RST;
            ctrlOne <= CTRL_ONE_RST;
            lcdCom <= '0;
            wakeSel <= '0;
            pullA <= '0;
            pullB <= '0;
            irqStat <= '0;
            irqMask <= '0;
            lowPower <= 1'b0;
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            ctrlZero <= next_ctrlZero;
            ctrlOne <= next_ctrlOne;
            lcdCom <= next_lcdCom;
            wakeSel <= next_wakeSel;
            pullA <= next_pullA;
            pullB <= next_pullB;
            irqStat <= next_irqStat;
            irqMask <= next_irqMask;
            lowPower <= next_lowPower;
            wb_ack_o <= next_ack;
            wb_dat_o <= next_dat;
        end
    end

    // ************************************************
    // glitch-free system clock switch
    // ************************************************

    // gate the core clock for a settle time between sources
    always_comb begin
        next_ckState = ckState;
        next_settle = settle;
        unique case (ckState)
            SCR_CK_FAST: begin
                next_settle = 2'(SWITCH_CYCLES);
                if (modeValid && ctrlZero[0]) next_ckState = SCR_CK_GATE;
            end
            SCR_CK_GATE: begin
                // request withdrawn while gated: stay on the fast source
                if (!(modeValid && ctrlZero[0])) next_ckState = SCR_CK_FAST;
                else if (settle != 2'h0) next_settle = settle - 2'h1;
                else if (slowXtalTick) next_ckState = SCR_CK_SLOW;
            end
            SCR_CK_SLOW: begin
                next_settle = 2'(SWITCH_CYCLES);
                if (!(modeValid && ctrlZero[0])) next_ckState = SCR_CK_BACK;
            end
            SCR_CK_BACK: begin
                if (settle != 2'h0) next_settle = settle - 2'h1;
                else if (fastRcTick) next_ckState = SCR_CK_FAST;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            ckState <= SCR_CK_FAST;
            settle <= '0;
        end else begin
            ckState <= next_ckState;
            settle <= next_settle;
        end
    end

    // ************************************************
    // outputs
    // ************************************************

    assign sysClkSlow = (ckState == SCR_CK_SLOW);
    assign sysClkGate = ckState[0] ^ ckState[1];
    assign fastRcEnable = !sysClkSlow && !lowPower;
    assign watchdogEnable = wdogOption
        || (ctrlOne[WDOG_POS +: 4] != WDOG_OFF_CODE);
    assign wakeUp = lowPower && |(paFall & wakeSel);
    assign portAPullEn = pullA & portADirIn;
    assign portBPullEn = pullB & portBDirIn;
    assign lcdComEnable = lcdCom[3:0];
    assign lcdComDrive = lcdCom[7:4];
    assign extRcPinSel = (oscConfig == SCR_OSC_EXT_RC);
    assign irq = |(irqStat & irqMask);

    // ************************************************
    // checks
    // ************************************************

    chk_mode_ignored: assert property (
        @(posedge mclk) disable iff (!rst_b)
        !modeValid |-> ##2 !sysClkSlow)
        else $error("clock mode acted outside combined configuration");
    chk_slow_stops_rc: assert property (
        @(posedge mclk) disable iff (!rst_b)
        sysClkSlow |-> !fastRcEnable)
        else $error("fast rc running while slow clock selected");
    chk_fast_default: assert property (
        @(posedge mclk) disable iff (!rst_b)
        (ckState == SCR_CK_FAST) && !lowPower |-> fastRcEnable)
        else $error("fast rc stopped in fast mode");
    chk_wdog_code: assert property (
        @(posedge mclk) disable iff (!rst_b)
        (!wdogOption && ctrlOne[3:0] == WDOG_OFF_CODE) == !watchdogEnable)
        else $error("watchdog enable mismatch");
    chk_ext_edge: assert property (
        @(posedge mclk) disable iff (!rst_b)
        extHit |=> irqStat[IRQ_EXT])
        else $error("external edge lost");
    chk_edge_off: assert property (
        @(posedge mclk) disable iff (!rst_b)
        ctrlOne[7:6] == EDGE_NONE |-> !extHit)
        else $error("edge seen while disabled");
    chk_wake_exit: assert property (
        @(posedge mclk) disable iff (!rst_b)
        wakeUp |=> !lowPower && irqStat[IRQ_WAKE])
        else $error("wake did not leave low power");
    chk_halt_enter: assert property (
        @(posedge mclk) disable iff (!rst_b)
        haltExec && !wakeUp |=> lowPower)
        else $error("halt did not enter low power");
    chk_gate_switch: assert property (
        @(posedge mclk) disable iff (!rst_b)
        $rose(sysClkSlow) |-> $past(sysClkGate))
        else $error("clock switched without gating");
    chk_reset_value: assert property (
        @(posedge mclk)
        !rst_b |=> ctrlOne == CTRL_ONE_RST)
        else $error("control one reset value wrong");
endmodule

// File: scr_timebase.sv
// time base divider on the selected source clock tick
`timescale 1ns/1ps
module scr_timebase import scr_pkg::*; (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // source tick and period select
    input wire logic srcTick,
    input wire logic [1:0] periodSel,
    // one-cycle period pulse
    output logic tbPulse
);
    logic [13:0] count;
    logic [13:0] next_count;
    logic next_tbPulse;

    // count source ticks up to 2^(10+sel)-1
    always_comb begin
        next_count = count;
        next_tbPulse = 1'b0;
        if (srcTick) begin
            if (count >= scr_tb_limit(periodSel)) begin
                next_count = '0;
                next_tbPulse = 1'b1;
            end else begin
                next_count = count + 14'h0001;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            count <= '0;
            tbPulse <= 1'b0;
        end else begin
            count <= next_count;
            tbPulse <= next_tbPulse;
        end
    end

    chk_tb_pulse_tick: assert property (
        @(posedge mclk) disable iff (!rst_b)
        tbPulse |-> $past(srcTick))
        else $error("time base pulse without source tick");
endmodule

// File: system_control_registers_tb_top.sv
// self-checking testbench for the system control register bank
`timescale 1ns/1ps
module system_control_registers_tb_top import scr_pkg::*;;
    // clock, reset and bus
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
    logic [7:0] wbAdr = 8'h00;
    logic [3:0] wbSel = 4'h0;
    logic [31:0] wbDatI = 32'h0000_0000;
    logic [31:0] wbDatO;
    logic wbAck;
    // device side inputs
    logic [2:0] oscConfig = 3'h2;
    logic wdogOption = 1'b0, fastRcTick = 1'b0, slowXtalTick = 1'b0;
    logic slowRcTick = 1'b0, haltExec = 1'b0, extIrqPin = 1'b0;
    logic [7:0] portAIn = 8'hFF, portADirIn = 8'h00, portBDirIn = 8'h00;
    // device side outputs
    logic fastRcEnable, sysClkSlow, sysClkGate, watchdogEnable, watchdogTick;
    logic timebaseTick, lowPower, wakeUp, extRcPinSel, irq;
    logic [7:0] portAPullEn, portBPullEn;
    logic [3:0] lcdComDrive, lcdComEnable;
    int errors = 0, nTests = 0, cycles = 0, seed = 35410;
    logic [31:0] rd, rv, dv;

    always #2.5 mclk = ~mclk;

    scr_regs dut_u (.mclk(mclk), .rst_b(rst_b), .wb_cyc_i(wbCyc),
        .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
        .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
        .oscConfig(oscConfig), .wdogOption(wdogOption),
        .fastRcTick(fastRcTick), .slowXtalTick(slowXtalTick),
        .slowRcTick(slowRcTick), .haltExec(haltExec), .portAIn(portAIn),
        .portADirIn(portADirIn), .portBDirIn(portBDirIn),
        .extIrqPin(extIrqPin), .fastRcEnable(fastRcEnable),
        .sysClkSlow(sysClkSlow), .sysClkGate(sysClkGate),
        .watchdogEnable(watchdogEnable),
        .watchdogTick(watchdogTick), .timebaseTick(timebaseTick),
        .lowPower(lowPower), .wakeUp(wakeUp), .portAPullEn(portAPullEn),
        .portBPullEn(portBPullEn), .lcdComDrive(lcdComDrive),
        .lcdComEnable(lcdComEnable), .extRcPinSel(extRcPinSel), .irq(irq));

    // ****************************************
    // shared tasks and expectation functions
    // ****************************************
    task automatic give_verdict();
        if (errors == 0 && nTests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        nTests++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one classic cycle: hold everything until ack is sampled high
    task automatic wbXfer(input logic we, input logic [7:0] adr,
                          input logic [7:0] wd, output logic [31:0] data);
        int k;
        @(posedge mclk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbSel <= 4'h1;
        wbDatI <= {24'h00_0000, wd};
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (wbAck !== 1'b1 && k < 50);
        if (k >= 50) errors++;
        data = wbDatO;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] adr, input logic [7:0] wd);
        logic [31:0] junk;
        wbXfer(1'b1, adr, wd, junk);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask

    function automatic logic wdogExp(input logic opt, input logic [3:0] c);
        return opt | (c != WDOG_OFF_CODE);
    endfunction

    // bounded wait at falling edges for a settled level
    task automatic waitFor(ref logic sig, input logic lvl);
        int k;
        k = 0;
        while (sig !== lvl && k < 40) begin
            @(negedge mclk);
            k++;
        end
    endtask

    // run-length guard
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            errors++;
            give_verdict();
        end
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        cyc(12);
        rst_b <= 1'b1;
        // reset values and an unmapped place
        wbXfer(1'b0, ADDR_CTRL_ONE, 8'h00, rd);
        check("ctrlOne reset", rd, 32'h0000_008A);
        wbXfer(1'b0, ADDR_CTRL_ZERO, 8'h00, rd);
        check("ctrlZero reset", rd, 32'h0000_0000);
        wr(8'h3C, 8'hFF);
        wbXfer(1'b0, 8'h3C, 8'h00, rd);
        check("unmapped read", rd, 32'h0000_0000);
        @(negedge mclk);
        check("wdog at reset", watchdogEnable, 1'b0);
        check("fast rc at reset", fastRcEnable, 1'b1);
        check("irq at reset", irq, 1'b0);
        // every watchdog code with a random option setting
        for (int i = 0; i < 16; i++) begin
            @(posedge mclk);
            wdogOption <= 1'($random(seed));
            wr(ADDR_CTRL_ONE, {4'h8, 4'(i)});
            @(negedge mclk);
            rv = 32'(wdogExp(wdogOption, 4'(i)));
            check("wdog enable", watchdogEnable, rv);
        end
        // every edge code; bit0 masked only for the rising-only code
        for (int e = 0; e < 4; e++) begin
            wr(ADDR_CTRL_ONE, {2'(e), 2'b00, WDOG_ON_CODE});
            wr(ADDR_IRQ_MASK, {7'h00, 1'(e != 1)});
            wr(ADDR_IRQ_STAT, 8'h07);
            extIrqPin <= 1'b1;
            cyc(6);
            @(negedge mclk);
            check("irq after rise", irq, 1'(e == 3));
            wbXfer(1'b0, ADDR_IRQ_STAT, 8'h00, rd);
            check("rise flag", rd[0], 1'(e == 1 || e == 3));
            wr(ADDR_IRQ_STAT, 8'h07);
            extIrqPin <= 1'b0;
            cyc(6);
            wbXfer(1'b0, ADDR_IRQ_STAT, 8'h00, rd);
            check("fall flag", rd[0], 1'(e >= 2));
        end
        // time base periods for all four codes on the slow rc tick
        for (int s = 0; s < 4; s++) begin
            wr(ADDR_CTRL_ONE, {2'b10, 2'(s), WDOG_ON_CODE});
            wr(ADDR_IRQ_STAT, 8'h07);
            @(posedge mclk);
            slowRcTick <= 1'b1;
            cyc((1 << (10 + s)) - 1);
            slowRcTick <= 1'b0;
            @(negedge mclk);
            check("wdog tick", watchdogTick, 1'b0);
            wbXfer(1'b0, ADDR_IRQ_STAT, 8'h00, rd);
            check("tb early", rd[1], 1'b0);
            slowRcTick <= 1'b1;
            @(negedge mclk);
            check("tb tick", timebaseTick, 1'b1);
            check("wdog tick on", watchdogTick, 1'b1);
            @(posedge mclk);
            slowRcTick <= 1'b0;
            cyc(4);
            wbXfer(1'b0, ADDR_IRQ_STAT, 8'h00, rd);
            check("tb period", rd[1], 1'b1);
        end
        // clock mode ignored outside fast rc plus slow crystal
        slowXtalTick <= 1'b1;
        fastRcTick <= 1'b1;
        wr(ADDR_CTRL_ZERO, 8'h01);
        cyc(10);
        @(negedge mclk);
        check("mode ignored", sysClkSlow, 1'b0);
        check("ext rc pin", extRcPinSel, 1'b0);
        @(posedge mclk);
        oscConfig <= 3'h3;
        cyc(1);
        @(negedge mclk);
        check("gating", sysClkGate, 1'b1);
        waitFor(sysClkSlow, 1'b1);
        check("slow clock", sysClkSlow, 1'b1);
        check("gate off", sysClkGate, 1'b0);
        check("fast rc stop", fastRcEnable, 1'b0);
        wr(ADDR_CTRL_ZERO, 8'h00);
        waitFor(sysClkSlow, 1'b0);
        check("fast clock", sysClkSlow, 1'b0);
        check("fast rc run", fastRcEnable, 1'b1);
        @(posedge mclk);
        oscConfig <= 3'h1;
        @(negedge mclk);
        check("ext rc pin", extRcPinSel, 1'b1);
        // halt, a falling edge on a disabled pin, then on the enabled one
        @(posedge mclk);
        oscConfig <= 3'h2;
        wr(ADDR_CTRL_ZERO, 8'h01);
        wr(ADDR_WAKE_SEL, 8'h04);
        wr(ADDR_IRQ_STAT, 8'h07);
        haltExec <= 1'b1;
        @(posedge mclk);
        haltExec <= 1'b0;
        portAIn <= 8'hF7;
        cyc(6);
        @(negedge mclk);
        check("halt", lowPower, 1'b1);
        @(posedge mclk);
        portAIn <= 8'hF3;
        cyc(2);
        @(negedge mclk);
        check("wake pulse", wakeUp, 1'b1);
        cyc(6);
        @(negedge mclk);
        check("woken", lowPower, 1'b0);
        wbXfer(1'b0, ADDR_IRQ_STAT, 8'h00, rd);
        check("wake flag", rd[2], 1'b1);
        // random pull-high selections and lcd common-line control
        for (int r = 0; r < 6; r++) begin
            rv = $random(seed);
            dv = $random(seed);
            @(posedge mclk);
            portADirIn <= dv[7:0];
            portBDirIn <= dv[15:8];
            wr(ADDR_PULL_A, rv[7:0]);
            wr(ADDR_PULL_B, rv[15:8]);
            wr(ADDR_LCD_COM, rv[23:16]);
            @(negedge mclk);
            check("pull a", portAPullEn, rv[7:0] & dv[7:0]);
            check("pull b", portBPullEn, rv[15:8] & dv[15:8]);
            check("com enable", lcdComEnable, rv[19:16]);
            check("com drive", lcdComDrive, rv[23:20]);
        end
        give_verdict();
    end
endmodule
